// file: verilog/tfi_id_regs.vh
/*
  tfi_id_regs.vh: offsets, field positions and reset values of the trace
  unit feature identification bank and its companion control registers.
  Assumes it is included once per module by its bare name.
*/
`ifndef TFI_ID_REGS_VH
`define TFI_ID_REGS_VH

// word offsets on the register port (byte addresses)
`define TFI_OFF_FEATURE   8'h00
`define TFI_OFF_RESOURCE  8'h04
`define TFI_OFF_PE_SEL    8'h08
`define TFI_OFF_STALL     8'h0c
`define TFI_OFF_SYNC      8'h10
`define TFI_OFF_VIEW      8'h14
`define TFI_OFF_ACCESS    8'h18
`define TFI_OFF_CC_THR    8'h1c

// feature word fields
`define TFI_F_PE_HI       30
`define TFI_F_PE_LO       28
`define TFI_F_SYS_STALL   27
`define TFI_F_STALL_REG   26
`define TFI_F_SYNC_FIX    25
`define TFI_F_ERR_TRC     24
`define TFI_F_NS_HI       23
`define TFI_F_NS_LO       20
`define TFI_F_S_HI        19
`define TFI_F_S_LO        16
`define TFI_F_CCMIN_HI    11
`define TFI_F_CCMIN_LO    0

// resource count word fields
`define TFI_R_VM_HI       31
`define TFI_R_VM_LO       28
`define TFI_R_CTX_HI      27
`define TFI_R_CTX_LO      24
`define TFI_R_SS_HI       23
`define TFI_R_SS_LO       20
`define TFI_R_RP_HI       19
`define TFI_R_RP_LO       16

// control register fields
`define TFI_C_PE_HI       2
`define TFI_C_PE_LO       0
`define TFI_C_STALL_EN    0
`define TFI_C_SYNC_HI     4
`define TFI_C_SYNC_LO     0
`define TFI_C_VIEW_ERR    7
`define TFI_C_ACC_S_HI    11
`define TFI_C_ACC_S_LO    8
`define TFI_C_ACC_NS_HI   15
`define TFI_C_ACC_NS_LO   12
`define TFI_C_THR_HI      11
`define TFI_C_THR_LO      0

// reset values and limits
`define TFI_ZERO32        32'h0000_0000
`define TFI_SYNC_RST      5'h08
`define TFI_CNT_MAX       4'h8
`define TFI_EL_NS_MASK    4'h7
`define TFI_EL_S_MASK     4'hb

`endif

// file: verilog/tfi_id_bank.v
/*
  tfi_id_bank: read-only feature and resource identification words of a
  trace unit, plus the small control registers whose shape they describe.
  A small EL mask module, shared by the view and access fields, follows it.
  Assumes a synchronous register port on clk with one-cycle strobes and
  a master that never waits; all inputs are synchronous to clk.
*/
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "tfi_id_regs.vh"

// Notes on behaviour
// [R01] feature bits 30:28 hold traceable PE count minus one, one to eight
// [R02] PE select control never exceeds the implemented PE count field
// [R03] feature bit 27 is one when system can stall the PE
// [R04] stall works only when system stall and stall register bits are set
// [R05] feature bit 26 is one when the stall control register exists
// [R06] feature bit 25 zero for writable sync period, one when fixed
// [R07] feature bit 24 is one when error-trace control bit exists
// [R08] bits 23:20 non-secure EL0..EL2 support; bit 23 reads zero
// [R09] EL bits in access type and view control exist only if supported
// [R10] bits 19:16 secure EL0, EL1, EL3 support; bit 18 reads zero
// [R11] bits 11:0 give least programmable cycle count threshold
// [R12] minimum threshold at least one with cycle counting, else zero
// [R13] resource bits 31:28 VMID comparator count, zero to eight
// [R14] resource bits 27:24 context comparator count, zero to eight
// [R15] resource bits 23:20 single-shot control count, zero to eight
// [R16] both identification words are 32-bit constants, read-only
// [R17] resource bits 19:16 resource pair count minus one, one to sixteen
// [R18] reads have no side effect; writes to identification words ignored
module tfi_id_bank #(
  parameter PE_COUNT      = 1,
  parameter SYS_STALL     = 1,
  parameter STALL_REG     = 1,
  parameter SYNC_FIXED    = 0,
  parameter ERR_TRACE     = 1,
  parameter [3:0] NS_EL   = 4'h7,
  parameter [3:0] S_EL    = 4'hb,
  parameter CC_IMPL       = 1,
  parameter [11:0] CC_MIN = 12'h001,
  parameter VM_CMP        = 0,
  parameter CTX_CMP       = 0,
  parameter SS_CTL        = 0,
  parameter RES_PAIRS     = 1
) (
  // clock, reset, enable
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ce,
  // register port
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [31:0] rd_data_q,
  // control state toward the trace logic
  output reg  [2:0]  pe_select_q,
  output reg         stall_enable_q,
  output reg         stall_active_q,
  output reg  [4:0]  sync_period_q,
  output reg         error_trace_en_q,
  output reg  [3:0]  view_el_s_q,
  output reg  [3:0]  view_el_ns_q,
  output reg  [3:0]  acc_el_s_q,
  output reg  [3:0]  acc_el_ns_q,
  output reg  [11:0] cc_threshold_q
);

  // integer copies so each field takes an explicit slice, never a silent cut
  localparam integer PE_M1 = PE_COUNT - 1;
  localparam integer RP_M1 = RES_PAIRS - 1;
  localparam integer VM_I  = VM_CMP;
  localparam integer CTX_I = CTX_CMP;
  localparam integer SS_I  = SS_CTL;

  // settings above range saturate to the largest legal code; PE and pair counts below one give zero
  localparam [2:0] PE_FIELD = (PE_COUNT < 1) ? 3'h0 :
                              (PE_COUNT > 8) ? 3'h7 : PE_M1[2:0];
  localparam [3:0] VM_FIELD  = (VM_CMP  > 8) ? `TFI_CNT_MAX : VM_I[3:0];
  localparam [3:0] CTX_FIELD = (CTX_CMP > 8) ? `TFI_CNT_MAX : CTX_I[3:0];
  localparam [3:0] SS_FIELD  = (SS_CTL  > 8) ? `TFI_CNT_MAX : SS_I[3:0];
  localparam [3:0] RP_FIELD  = (RES_PAIRS < 1)  ? 4'h0 :
                               (RES_PAIRS > 16) ? 4'hf : RP_M1[3:0];
  localparam [11:0] CC_FIELD = (CC_IMPL == 0) ? 12'h000 :
                               (CC_MIN == 12'h000) ? 12'h001 : CC_MIN;
  localparam [3:0] NS_FIELD  = NS_EL & `TFI_EL_NS_MASK;
  localparam [3:0] S_FIELD   = S_EL & `TFI_EL_S_MASK;
  localparam       STALL_OK  = (SYS_STALL != 0) && (STALL_REG != 0);

  reg [31:0] feature_w;
  reg [31:0] resource_w;
  reg [31:0] rd_mux;
  reg [2:0]  pe_wr;
  reg [11:0] thr_wr;
  wire [3:0] view_s_kept;
  wire [3:0] view_ns_kept;
  wire [3:0] acc_s_kept;
  wire [3:0] acc_ns_kept;

  // [R09] one mask per EL field
  tfi_el_mask #(
    .SUPPORT (S_FIELD)
  ) view_s_mask (
    .raw  (wdata[`TFI_F_S_HI:`TFI_F_S_LO]),
    .kept (view_s_kept)
  );

  tfi_el_mask #(
    .SUPPORT (NS_FIELD)
  ) view_ns_mask (
    .raw  (wdata[`TFI_F_NS_HI:`TFI_F_NS_LO]),
    .kept (view_ns_kept)
  );

  tfi_el_mask #(
    .SUPPORT (S_FIELD)
  ) acc_s_mask (
    .raw  (wdata[`TFI_C_ACC_S_HI:`TFI_C_ACC_S_LO]),
    .kept (acc_s_kept)
  );

  tfi_el_mask #(
    .SUPPORT (NS_FIELD)
  ) acc_ns_mask (
    .raw  (wdata[`TFI_C_ACC_NS_HI:`TFI_C_ACC_NS_LO]),
    .kept (acc_ns_kept)
  );

  // [R16] constant feature word
  always @* begin
    feature_w = `TFI_ZERO32;
    // [R01] PE count field
    feature_w[`TFI_F_PE_HI:`TFI_F_PE_LO] = PE_FIELD;
    // [R03] system stall bit
    feature_w[`TFI_F_SYS_STALL] = (SYS_STALL != 0);
    // [R05] stall register present
    feature_w[`TFI_F_STALL_REG] = (STALL_REG != 0);
    // [R06] fixed sync period
    feature_w[`TFI_F_SYNC_FIX] = (SYNC_FIXED != 0);
    // [R07] error-trace control
    feature_w[`TFI_F_ERR_TRC] = (ERR_TRACE != 0);
    // [R08] non-secure EL, top bit masked
    feature_w[`TFI_F_NS_HI:`TFI_F_NS_LO] = NS_FIELD;
    // [R10] secure EL, bit 18 masked
    feature_w[`TFI_F_S_HI:`TFI_F_S_LO] = S_FIELD;
    // [R11] [R12] minimum threshold
    feature_w[`TFI_F_CCMIN_HI:`TFI_F_CCMIN_LO] = CC_FIELD;
  end

  // [R16] constant resource count word
  always @* begin
    resource_w = `TFI_ZERO32;
    // [R13] VMID comparators
    resource_w[`TFI_R_VM_HI:`TFI_R_VM_LO] = VM_FIELD;
    // [R14] context comparators
    resource_w[`TFI_R_CTX_HI:`TFI_R_CTX_LO] = CTX_FIELD;
    // [R15] single-shot controls
    resource_w[`TFI_R_SS_HI:`TFI_R_SS_LO] = SS_FIELD;
    // [R17] resource pairs minus one
    resource_w[`TFI_R_RP_HI:`TFI_R_RP_LO] = RP_FIELD;
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rd_mux = `TFI_ZERO32;
    case (addr)
      `TFI_OFF_FEATURE: begin
        rd_mux = feature_w;
      end
      `TFI_OFF_RESOURCE: begin
        rd_mux = resource_w;
      end
      `TFI_OFF_PE_SEL: begin
        rd_mux[`TFI_C_PE_HI:`TFI_C_PE_LO] = pe_select_q;
      end
      `TFI_OFF_STALL: begin
        rd_mux[`TFI_C_STALL_EN] = stall_enable_q;
      end
      `TFI_OFF_SYNC: begin
        rd_mux[`TFI_C_SYNC_HI:`TFI_C_SYNC_LO] = sync_period_q;
      end
      `TFI_OFF_VIEW: begin
        rd_mux[`TFI_C_VIEW_ERR] = error_trace_en_q;
        rd_mux[`TFI_F_S_HI:`TFI_F_S_LO] = view_el_s_q;
        rd_mux[`TFI_F_NS_HI:`TFI_F_NS_LO] = view_el_ns_q;
      end
      `TFI_OFF_ACCESS: begin
        rd_mux[`TFI_C_ACC_S_HI:`TFI_C_ACC_S_LO] = acc_el_s_q;
        rd_mux[`TFI_C_ACC_NS_HI:`TFI_C_ACC_NS_LO] = acc_el_ns_q;
      end
      `TFI_OFF_CC_THR: begin
        rd_mux[`TFI_C_THR_HI:`TFI_C_THR_LO] = cc_threshold_q;
      end
      default: begin
        rd_mux = `TFI_ZERO32;
      end
    endcase
  end

  // [R02] clamp PE select to count
  always @* begin
    pe_wr = wdata[`TFI_C_PE_HI:`TFI_C_PE_LO];
    if (pe_wr > PE_FIELD) begin
      pe_wr = PE_FIELD;
    end
  end

  // [R12] threshold not below minimum
  always @* begin
    thr_wr = wdata[`TFI_C_THR_HI:`TFI_C_THR_LO];
    if (CC_IMPL == 0) begin
      thr_wr = 12'h000;
    end else if (thr_wr < CC_FIELD) begin
      thr_wr = CC_FIELD;
    end
  end

  // read data stands from the strobe until the next enabled cycle
  always @(posedge clk) begin
    if (!rst_b) begin
      rd_data_q <= `TFI_ZERO32;
    end else if (ce) begin
      // [R18] reads only sample, no side effects
      if (rd_en) begin
        rd_data_q <= rd_mux;
      end else begin
        rd_data_q <= `TFI_ZERO32;
      end
    end
  end

  // control registers; writes to the id words fall through untouched
  always @(posedge clk) begin
    if (!rst_b) begin
      pe_select_q      <= 3'h0;
      stall_enable_q   <= 1'b0;
      sync_period_q    <= `TFI_SYNC_RST;
      error_trace_en_q <= 1'b0;
      view_el_s_q      <= 4'h0;
      view_el_ns_q     <= 4'h0;
      acc_el_s_q       <= 4'h0;
      acc_el_ns_q      <= 4'h0;
      cc_threshold_q   <= CC_FIELD;
    end else if (ce && wr_en) begin
      case (addr)
        `TFI_OFF_PE_SEL: begin
          // [R02] bounded selection
          pe_select_q <= pe_wr;
        end
        `TFI_OFF_STALL: begin
          // [R05] absent register ignores writes
          if (STALL_REG != 0) begin
            stall_enable_q <= wdata[`TFI_C_STALL_EN];
          end
        end
        `TFI_OFF_SYNC: begin
          // [R06] fixed period is read-only
          if (SYNC_FIXED == 0) begin
            sync_period_q <= wdata[`TFI_C_SYNC_HI:`TFI_C_SYNC_LO];
          end
        end
        `TFI_OFF_VIEW: begin
          // [R07] error bit only if implemented
          error_trace_en_q <= wdata[`TFI_C_VIEW_ERR] & (ERR_TRACE != 0);
          // [R09] unsupported EL bits stay zero
          view_el_s_q  <= view_s_kept;
          view_el_ns_q <= view_ns_kept;
        end
        `TFI_OFF_ACCESS: begin
          // [R09] access type EL masking
          acc_el_s_q  <= acc_s_kept;
          acc_el_ns_q <= acc_ns_kept;
        end
        `TFI_OFF_CC_THR: begin
          // [R11] threshold held at or above minimum
          cc_threshold_q <= thr_wr;
        end
        default: begin
          // [R18] id words and holes ignore writes
          pe_select_q <= pe_select_q;
        end
      endcase
    end
  end

  // [R04] stall needs both capability bits
  always @(posedge clk) begin
    if (!rst_b) begin
      stall_active_q <= 1'b0;
    end else if (ce) begin
      // registered so the output comes from a flop; one cycle behind enable
      stall_active_q <= stall_enable_q & STALL_OK;
    end
  end

endmodule

// keeps only the EL bits the implementation supports
module tfi_el_mask #(
  parameter [3:0] SUPPORT = 4'h0
) (
  // requested EL bits
  input  wire [3:0] raw,
  // supported subset
  output wire [3:0] kept
);

  // [R09] unsupported EL bits read as zero
  assign kept = raw & SUPPORT;

endmodule

// file: tb/tfi_id_properties.sv
/*
  tfi_id_properties: port-level assertions for the id bank.
  Assumes binding into every tfi_id_bank; sees only its ports.
*/
`timescale 1ns/1ps
module tfi_id_properties #(
  parameter SYS_STALL = 1,
  parameter STALL_REG = 1,
  parameter CC_IMPL   = 1
) (
  // clock and reset
  input wire        clk,
  input wire        rst_b,
  input wire        ce,
  // register port
  input wire [7:0]  addr,
  input wire        wr_en,
  input wire        rd_en,
  input wire [31:0] rd_data_q,
  // control outputs
  input wire [2:0]  pe_select_q,
  input wire        stall_enable_q,
  input wire        stall_active_q,
  input wire [4:0]  sync_period_q,
  input wire [3:0]  view_el_s_q,
  input wire [3:0]  view_el_ns_q,
  input wire [3:0]  acc_el_s_q,
  input wire [3:0]  acc_el_ns_q,
  input wire [11:0] cc_threshold_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rd_f = ce && rd_en && addr == 8'h00;
  wire rd_r = ce && rd_en && addr == 8'h04;
  a_read_idle: assert property ($past(ce) && !$past(rd_en) |-> rd_data_q == 32'h0000_0000)
    else $error("read data not idle");
  a_fixed_zero_bits: assert property (rd_f |=> rd_data_q[31] == 1'b0
    && rd_data_q[23] == 1'b0 && rd_data_q[18] == 1'b0 && rd_data_q[15:12] == 4'h0)
    else $error("zero bits set");
  a_pe_clamp: assert property (rd_f |=> pe_select_q <= rd_data_q[30:28])
    else $error("pe select above count");
  a_stall_gate: assert property ($past(ce) && $past(rst_b) |->
    stall_active_q == ($past(stall_enable_q) && SYS_STALL != 0 && STALL_REG != 0))
    else $error("stall gate");
  a_thr_floor: assert property (rd_f |=> cc_threshold_q >= rd_data_q[11:0])
    else $error("threshold below minimum");
  a_min_nonzero: assert property (rd_f |=>
    (rd_data_q[11:0] != 12'h000) == (CC_IMPL != 0)) else $error("minimum threshold wrong");
  a_id_write_ignored: assert property (ce && wr_en && addr == 8'h00 |=>
    $stable(pe_select_q) && $stable(sync_period_q)) else $error("id write had effect");
  a_el_unimpl: assert property (view_el_ns_q[3] == 1'b0 && acc_el_ns_q[3] == 1'b0
    && view_el_s_q[2] == 1'b0 && acc_el_s_q[2] == 1'b0) else $error("unimplemented el bit set");
  a_count_range: assert property (rd_r |=> rd_data_q[31:28] <= 4'h8
    && rd_data_q[27:24] <= 4'h8 && rd_data_q[23:20] <= 4'h8 && rd_data_q[15:0] == 16'h0000)
    else $error("count out of range");
endmodule

bind tfi_id_bank tfi_id_properties #(.SYS_STALL(SYS_STALL), .STALL_REG(STALL_REG),
  .CC_IMPL(CC_IMPL)) tfi_id_properties_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .pe_select_q(pe_select_q),
  .stall_enable_q(stall_enable_q), .stall_active_q(stall_active_q),
  .sync_period_q(sync_period_q), .view_el_s_q(view_el_s_q), .view_el_ns_q(view_el_ns_q),
  .acc_el_s_q(acc_el_s_q), .acc_el_ns_q(acc_el_ns_q), .cc_threshold_q(cc_threshold_q));

// file: tb/test_trace_unit_feature_id_regs.sv
/*
  test_trace_unit_feature_id_regs: self-checking bench of the id bank.
  Assumes the bank and its checker are compiled alongside.
*/
`timescale 1ns/1ps
module test_trace_unit_feature_id_regs;
  localparam integer PE_N   = 3;
  localparam integer VM_N   = 8;
  localparam integer CTX_N  = 5;
  localparam integer SS_N   = 2;
  localparam integer RP_N   = 16;
  localparam [3:0]   NS_SUP = 4'hf;
  localparam [3:0]   S_SUP  = 4'hf;
  localparam [2:0]   PE_M1  = PE_N - 1;
  localparam [3:0]   RP_M1  = RP_N - 1;
  localparam [11:0]  CMIN   = 12'h005;
  localparam [31:0]  FEAT   = {1'b0, PE_M1, 4'hd, NS_SUP & 4'h7, S_SUP & 4'hb, 4'h0, CMIN};
  localparam [31:0]  RES    = {VM_N[3:0], CTX_N[3:0], SS_N[3:0], RP_M1, 16'h0000};
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         ce = 1'b1;
  reg  [7:0]  addr = 8'h00;
  reg  [31:0] wdata = 32'h0000_0000;
  reg         wr_en = 1'b0;
  reg         rd_en = 1'b0;
  reg  [31:0] seed = 32'h0000_005e;
  wire [31:0] rd_data_q;
  wire [2:0]  pe_select_q;
  wire        stall_enable_q, stall_active_q, error_trace_en_q;
  wire [4:0]  sync_period_q;
  wire [3:0]  view_el_s_q, view_el_ns_q, acc_el_s_q, acc_el_ns_q;
  wire [11:0] cc_threshold_q;
  integer     bad_count = 0;
  integer     checks = 0;
  integer     cyc = 0;
  integer     i;

  always #2 clk = ~clk;

  tfi_id_bank #(.PE_COUNT(PE_N), .NS_EL(NS_SUP), .S_EL(S_SUP), .CC_MIN(CMIN), .VM_CMP(VM_N),
    .CTX_CMP(CTX_N), .SS_CTL(SS_N), .RES_PAIRS(RP_N)) tfi_id_bank_inst (.clk(clk), .rst_b(rst_b),
    .ce(ce), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
    .pe_select_q(pe_select_q), .stall_enable_q(stall_enable_q),
    .stall_active_q(stall_active_q), .sync_period_q(sync_period_q),
    .error_trace_en_q(error_trace_en_q), .view_el_s_q(view_el_s_q),
    .view_el_ns_q(view_el_ns_q), .acc_el_s_q(acc_el_s_q), .acc_el_ns_q(acc_el_ns_q),
    .cc_threshold_q(cc_threshold_q));

  function [31:0] nxt(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      nxt = t ^ (t << 5);
    end
  endfunction
  function [2:0] pe_exp(input [2:0] v);
    pe_exp = (v > PE_M1) ? PE_M1 : v;
  endfunction
  function [11:0] thr_exp(input [11:0] v);
    thr_exp = (v < CMIN) ? CMIN : v;
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data_q, e);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // whole run is about a hundred cycles; this only cuts a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      stop_test;
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(sync_period_q, 5'h08);
    chk(cc_threshold_q, CMIN);
    chk({pe_select_q, stall_enable_q, stall_active_q, error_trace_en_q}, 32'h0000_0000);
    chk({view_el_s_q, view_el_ns_q, acc_el_s_q, acc_el_ns_q}, 32'h0000_0000);
    chk(rd_data_q, 32'h0000_0000);
    rd(8'h00, FEAT);
    rd(8'h04, RES);
    rd(8'h20, 32'h0000_0000);
    seed = nxt(seed);
    wr(8'h00, seed);
    wr(8'h04, ~seed);
    rd(8'h00, FEAT);
    rd(8'h04, RES);
    $display("id words done");
    for (i = 0; i < 8; i = i + 1) begin
      seed = nxt(seed);
      wr(8'h08, {seed[31:3], i[2:0]});
      chk(pe_select_q, pe_exp(i[2:0]));
      wr(8'h1c, (i < 2) ? i : seed);
      chk(cc_threshold_q, thr_exp((i < 2) ? i[11:0] : seed[11:0]));
      wr(8'h14, seed);
      chk(view_el_ns_q, seed[23:20] & NS_SUP & 4'h7);
      chk(view_el_s_q, seed[19:16] & S_SUP & 4'hb);
      chk(error_trace_en_q, seed[7]);
      wr(8'h18, seed);
      chk(acc_el_ns_q, seed[15:12] & NS_SUP & 4'h7);
      chk(acc_el_s_q, seed[11:8] & S_SUP & 4'hb);
    end
    $display("controls done");
    wr(8'h0c, 32'h0000_0001);
    chk(stall_enable_q, 1'b1);
    @(posedge clk);
    #1;
    chk(stall_active_q, 1'b1);
    wr(8'h10, 32'h0000_0013);
    chk(sync_period_q, 5'h13);
    // read, then freeze while the read data still stands
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= 8'h00;
    @(posedge clk);
    rd_en <= 1'b0;
    ce    <= 1'b0;
    #1;
    chk(rd_data_q, FEAT);
    wr(8'h08, 32'h0000_0000);
    chk(rd_data_q, FEAT);
    chk(pe_select_q, PE_M1);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk(rd_data_q, 32'h0000_0000);
    $display("stall and enable done");
    // mid-run reset must restore PE select, stall active, sync period and threshold
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(pe_select_q, 3'h0);
    chk(stall_active_q, 1'b0);
    chk(sync_period_q, 5'h08);
    chk(cc_threshold_q, CMIN);
    rd(8'h04, RES);
    $display("reset done");
    stop_test;
  end
endmodule
